// [asbc_consts.vh]
// Constants for the asynchronous byte-wide memory bus host controller.
// Assumes a 125 MHz clock (8 ns period); times in ns, counts in cycles.
`ifndef ASBC_CONSTS_VH
`define ASBC_CONSTS_VH

`define ASBC_CLK_PERIOD_NS      8
`define ASBC_ADDR_W             13
`define ASBC_DATA_W             8
`define ASBC_CNT_W              6

// Fast grade times
`define ASBC_F_STROBE_MIN_NS    80
`define ASBC_F_SELECT_MIN_NS    80
`define ASBC_F_ADDR_VALID_NS    80
`define ASBC_F_SETUP_MIN_NS     50
`define ASBC_F_READ_ACCESS_NS   100
// Slow grade times
`define ASBC_S_STROBE_MIN_NS    100
`define ASBC_S_SELECT_MIN_NS    130
`define ASBC_S_ADDR_VALID_NS    130
`define ASBC_S_SETUP_MIN_NS     70
`define ASBC_S_READ_ACCESS_NS   150
// Grade independent times
`define ASBC_HOLD_MIN_NS        5
`define ASBC_RECOVERY_MIN_NS    10
`define ASBC_ADDR_SETUP_NS      0

// Least times round up to whole cycles, never below one
`define ASBC_CYC_UP(ns) (((ns) + `ASBC_CLK_PERIOD_NS - 1) / `ASBC_CLK_PERIOD_NS)
`define ASBC_CYC_MIN1(ns) ((`ASBC_CYC_UP(ns) < 1) ? 1 : `ASBC_CYC_UP(ns))

`endif

// [asbc_host.v]
// Host controller that runs read and write cycles on an asynchronous SRAM bus.
// Assumes the memory pins are sampled synchronously to clk_i and that the
// testbench resolves the byte lines from the output enable.
// Notes on behaviour
// - Write while strobe, both selects active
// - Address held steady through write
// - Address valid before any asserting edge
// - Address valid long enough before end
// - Strobe low at least minimum width
// - Selects asserted at least minimum width
// - Data valid before write end
// - Data held briefly after write end
// - Address held after write before next
// - Output drive high during writes
// - Read while strobe high, selects active
`timescale 1ns/10ps
`include "asbc_consts.vh"
module asbc_host (
  input  wire                    clk_i,
  input  wire                    rst_i,
  input  wire                    ce_i,
  input  wire                    slow_grade_i,
  input  wire                    req_valid_i,
  input  wire                    req_write_i,
  input  wire [`ASBC_ADDR_W-1:0] req_addr_i,
  input  wire [`ASBC_DATA_W-1:0] req_wdata_i,
  output reg                     req_ready_o,
  output reg                     rsp_valid_o,
  output reg  [`ASBC_DATA_W-1:0] rsp_rdata_o,
  output reg  [`ASBC_ADDR_W-1:0] mem_addr_o,
  output reg                     select_low_active_n_o,
  output reg                     select_high_active_o,
  output reg                     drive_n_o,
  output reg                     store_n_o,
  input  wire [`ASBC_DATA_W-1:0] byte_lines_i,
  output reg  [`ASBC_DATA_W-1:0] byte_lines_o,
  output reg                     byte_lines_oe_n_o
);
  localparam [2:0] ST_IDLE    = 3'd0;
  localparam [2:0] ST_WSETUP  = 3'd1;
  localparam [2:0] ST_WSTROBE = 3'd2;
  localparam [2:0] ST_WHOLD   = 3'd3;
  localparam [2:0] ST_RACCESS = 3'd4;
  localparam [2:0] ST_RCLOSE  = 3'd5;
  localparam [2:0] ST_RECOVER = 3'd6;

  localparam integer           F_WRITE_INT  = `ASBC_CYC_MIN1(`ASBC_F_SELECT_MIN_NS);
  localparam integer           S_WRITE_INT  = `ASBC_CYC_MIN1(`ASBC_S_SELECT_MIN_NS);
  localparam integer           F_READ_INT   = `ASBC_CYC_MIN1(`ASBC_F_READ_ACCESS_NS);
  localparam integer           S_READ_INT   = `ASBC_CYC_MIN1(`ASBC_S_READ_ACCESS_NS);
  localparam integer           HOLD_INT     = `ASBC_CYC_MIN1(`ASBC_HOLD_MIN_NS);
  localparam integer           RECOVER_INT  = `ASBC_CYC_MIN1(`ASBC_RECOVERY_MIN_NS);
  localparam integer           SETUP_INT    = `ASBC_CYC_MIN1(`ASBC_ADDR_SETUP_NS);
  // Counts fit the timer width; slice them down on purpose
  localparam [`ASBC_CNT_W-1:0] F_WRITE_CYC  = F_WRITE_INT[`ASBC_CNT_W-1:0];
  localparam [`ASBC_CNT_W-1:0] S_WRITE_CYC  = S_WRITE_INT[`ASBC_CNT_W-1:0];
  localparam [`ASBC_CNT_W-1:0] F_READ_CYC   = F_READ_INT[`ASBC_CNT_W-1:0];
  localparam [`ASBC_CNT_W-1:0] S_READ_CYC   = S_READ_INT[`ASBC_CNT_W-1:0];
  localparam [`ASBC_CNT_W-1:0] HOLD_CYC     = HOLD_INT[`ASBC_CNT_W-1:0];
  localparam [`ASBC_CNT_W-1:0] RECOVER_CYC  = RECOVER_INT[`ASBC_CNT_W-1:0];
  localparam [`ASBC_CNT_W-1:0] SETUP_CYC    = SETUP_INT[`ASBC_CNT_W-1:0];

  reg  [2:0]             state_q;
  reg  [2:0]             state_d;
  reg                    load;
  reg  [`ASBC_CNT_W-1:0] load_val;
  wire                   done;
  wire [`ASBC_CNT_W-1:0] write_cyc;
  wire [`ASBC_CNT_W-1:0] read_cyc;

  // The longest of strobe, select and address-to-end covers all three
  assign write_cyc = slow_grade_i ? S_WRITE_CYC : F_WRITE_CYC;
  assign read_cyc  = slow_grade_i ? S_READ_CYC : F_READ_CYC;

  asbc_timer u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .load_i  (load),
    .value_i (load_val),
    .done_o  (done)
  );

  always @* begin
    state_d  = state_q;
    load     = 1'b0;
    load_val = {`ASBC_CNT_W{1'b0}};
    case (state_q)
      ST_IDLE: begin
        if (req_valid_i) begin
          load = 1'b1;
          if (req_write_i) begin
            load_val = SETUP_CYC;
            state_d  = ST_WSETUP;
          end else begin
            load_val = read_cyc;
            state_d  = ST_RACCESS;
          end
        end
      end
      ST_WSETUP: begin
        if (done) begin
          load     = 1'b1;
          load_val = write_cyc;
          state_d  = ST_WSTROBE;
        end
      end
      ST_WSTROBE: begin
        if (done) begin
          load     = 1'b1;
          load_val = HOLD_CYC;
          state_d  = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        if (done) begin
          load     = 1'b1;
          load_val = RECOVER_CYC;
          state_d  = ST_RECOVER;
        end
      end
      ST_RACCESS: begin
        if (done) begin
          state_d = ST_RCLOSE;
        end
      end
      ST_RCLOSE: begin
        load     = 1'b1;
        load_val = RECOVER_CYC;
        state_d  = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q               <= ST_IDLE;
      req_ready_o           <= 1'b0;
      rsp_valid_o           <= 1'b0;
      rsp_rdata_o           <= {`ASBC_DATA_W{1'b0}};
      mem_addr_o            <= {`ASBC_ADDR_W{1'b0}};
      select_low_active_n_o <= 1'b1;
      select_high_active_o  <= 1'b0;
      drive_n_o             <= 1'b1;
      store_n_o             <= 1'b1;
      byte_lines_o          <= {`ASBC_DATA_W{1'b0}};
      byte_lines_oe_n_o     <= 1'b1;
    end else if (ce_i) begin
      state_q     <= state_d;
      rsp_valid_o <= 1'b0;
      req_ready_o <= (state_d == ST_IDLE);
      case (state_q)
        ST_IDLE: begin
          if (req_valid_i) begin
            mem_addr_o <= req_addr_i;
            if (req_write_i) begin
              byte_lines_o <= req_wdata_i;
            end
          end
        end
        ST_WSETUP: begin
          if (done) begin
            select_low_active_n_o <= 1'b0;
            select_high_active_o  <= 1'b1;
            store_n_o             <= 1'b0;
            drive_n_o             <= 1'b1;
            // Host drives only after the device has had time to float
            byte_lines_oe_n_o     <= 1'b0;
          end
        end
        ST_WSTROBE: begin
          if (done) begin
            store_n_o             <= 1'b1;
            select_low_active_n_o <= 1'b1;
            select_high_active_o  <= 1'b0;
          end
        end
        ST_WHOLD: begin
          if (done) begin
            byte_lines_oe_n_o <= 1'b1;
          end
        end
        ST_RACCESS: begin
          select_low_active_n_o <= 1'b0;
          select_high_active_o  <= 1'b1;
          drive_n_o             <= 1'b0;
          if (done) begin
            rsp_rdata_o <= byte_lines_i;
            rsp_valid_o <= 1'b1;
          end
        end
        ST_RCLOSE: begin
          select_low_active_n_o <= 1'b1;
          select_high_active_o  <= 1'b0;
          drive_n_o             <= 1'b1;
        end
        ST_RECOVER: begin
          mem_addr_o <= mem_addr_o;
        end
        default: begin
          select_low_active_n_o <= 1'b1;
          select_high_active_o  <= 1'b0;
          store_n_o             <= 1'b1;
          drive_n_o             <= 1'b1;
          byte_lines_oe_n_o     <= 1'b1;
        end
      endcase
    end
  end
endmodule

// [asbc_host_monitor.sv]
// Checker for the memory pins of the SRAM bus host.
// Assumes it is bound to asbc_host and sees only its ports.
`timescale 1ns/10ps
`include "asbc_consts.vh"
module asbc_host_monitor (
  input wire                    clk_i,
  input wire                    rst_i,
  input wire                    slow_grade_i,
  input wire                    rsp_valid_o,
  input wire [`ASBC_ADDR_W-1:0] mem_addr_o,
  input wire                    select_low_active_n_o,
  input wire                    select_high_active_o,
  input wire                    drive_n_o,
  input wire                    store_n_o,
  input wire [`ASBC_DATA_W-1:0] byte_lines_o,
  input wire                    byte_lines_oe_n_o
);
  reg [`ASBC_CNT_W-1:0] busy_q;
  // Cycles spent in the current strobe or read phase
  always @(posedge clk_i) begin
    busy_q <= (rst_i || (store_n_o && drive_n_o)) ? '0 : busy_q + 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_end; $rose(store_n_o); endsequence
  sequence wr_mid; !store_n_o && !$past(store_n_o); endsequence
  chk_write_selects: assert property (!store_n_o |-> !select_low_active_n_o && select_high_active_o)
    else $error("strobe low without both selects");
  chk_addr_steady: assert property (wr_mid |-> $stable(mem_addr_o))
    else $error("address moved inside write");
  chk_addr_setup: assert property ($fell(store_n_o) |-> $stable(mem_addr_o))
    else $error("address changed with strobe edge");
  chk_strobe_width: assert property (wr_end |->
      busy_q * `ASBC_CLK_PERIOD_NS >= (slow_grade_i ? `ASBC_S_SELECT_MIN_NS : `ASBC_F_SELECT_MIN_NS))
    else $error("write strobe too short");
  chk_data_setup: assert property (wr_mid |-> $stable(byte_lines_o) && !byte_lines_oe_n_o)
    else $error("write data not steady");
  chk_data_hold: assert property (wr_end |-> $stable(byte_lines_o) && !byte_lines_oe_n_o)
    else $error("write data released early");
  chk_addr_recovery: assert property (wr_end |-> $stable(mem_addr_o) ##1 $stable(mem_addr_o))
    else $error("address moved before recovery");
  chk_drive_off_wr: assert property (!store_n_o |-> drive_n_o)
    else $error("output drive low during write");
  chk_read_clean: assert property (!drive_n_o |-> store_n_o && byte_lines_oe_n_o)
    else $error("host drives lines during read");
  chk_read_wait: assert property (rsp_valid_o |->
      busy_q * `ASBC_CLK_PERIOD_NS >= (slow_grade_i ? `ASBC_S_READ_ACCESS_NS : `ASBC_F_READ_ACCESS_NS))
    else $error("read sampled before access time");
endmodule
bind asbc_host asbc_host_monitor u_mon (
  .clk_i                 (clk_i),
  .rst_i                 (rst_i),
  .slow_grade_i          (slow_grade_i),
  .rsp_valid_o           (rsp_valid_o),
  .mem_addr_o            (mem_addr_o),
  .select_low_active_n_o (select_low_active_n_o),
  .select_high_active_o  (select_high_active_o),
  .drive_n_o             (drive_n_o),
  .store_n_o             (store_n_o),
  .byte_lines_o          (byte_lines_o),
  .byte_lines_oe_n_o     (byte_lines_oe_n_o)
);

// [asbc_mem_model.sv]
// Behavioural byte-wide SRAM seen on the far side of the host.
// Assumes pins change on clock edges; shows inverted data until access time.
`timescale 1ns/10ps
`include "asbc_consts.vh"
module asbc_mem_model (
  input  wire                    clk_i,
  input  wire                    slow_i,
  input  wire [`ASBC_ADDR_W-1:0] addr_i,
  input  wire                    sel_n_i,
  input  wire                    sel_i,
  input  wire                    drive_n_i,
  input  wire                    store_n_i,
  input  wire [`ASBC_DATA_W-1:0] data_i,
  output wire [`ASBC_DATA_W-1:0] data_o,
  output wire                    drive_o
);
  reg [`ASBC_DATA_W-1:0] mem_q [0:8191];
  reg [7:0]              age_q;
  reg [`ASBC_ADDR_W-1:0] last_q;
  always @(posedge clk_i) begin
    if (!sel_n_i && sel_i && !store_n_i) mem_q[addr_i] <= data_i;
  end
  always @(posedge clk_i) begin
    last_q <= addr_i;
    age_q  <= (!drive_o || addr_i != last_q) ? 8'h00 : age_q + 8'h01;
  end
  assign drive_o = !sel_n_i && sel_i && !drive_n_i && store_n_i;
  assign data_o = ((age_q + 1) * `ASBC_CLK_PERIOD_NS >= (slow_i ? `ASBC_S_READ_ACCESS_NS : `ASBC_F_READ_ACCESS_NS))
                  ? mem_q[addr_i] : ~mem_q[addr_i];
endmodule

// [asbc_timer.v]
// Down counter that times one bus phase.
// Assumes load and count come from the owning state machine.
`timescale 1ns/10ps
`include "asbc_consts.vh"
module asbc_timer (
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire                   ce_i,
  input  wire                   load_i,
  input  wire [`ASBC_CNT_W-1:0] value_i,
  output wire                   done_o
);
  reg [`ASBC_CNT_W-1:0] cnt_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= {`ASBC_CNT_W{1'b0}};
    end else if (ce_i) begin
      if (load_i) begin
        cnt_q <= value_i;
      end else if (cnt_q != {`ASBC_CNT_W{1'b0}}) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Done looks only at the count: the state machine builds load from done
  assign done_o = (cnt_q == {`ASBC_CNT_W{1'b0}});
endmodule

// [test_async_sram_bus_cycles.sv]
// Self-checking bench for the SRAM bus host with a memory model.
// Assumes the bench resolves the byte lines from both enables.
`timescale 1ns/10ps
`include "asbc_consts.vh"
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_async_sram_bus_cycles;
  reg         clk_i = 0, rst_i = 1, ce_i = 1, slow = 0, rv = 0, rw = 0;
  reg  [12:0] ra = 0;
  reg  [7:0]  rd = 0;
  integer     n_mismatch = 0, check_count = 0;
  wire        rdy, rsp, sn, sh, dn, st, oen, mdrv;
  wire [12:0] addr;
  wire [7:0]  rdat, blo, mdat, bus;
  // Undriven lines toggle so stale data never looks valid
  assign bus = !oen ? blo : mdrv ? mdat : {8{clk_i}} ^ 8'ha5;
  asbc_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .slow_grade_i(slow), .req_valid_i(rv),
    .req_write_i(rw), .req_addr_i(ra), .req_wdata_i(rd), .req_ready_o(rdy), .rsp_valid_o(rsp),
    .rsp_rdata_o(rdat), .mem_addr_o(addr), .select_low_active_n_o(sn), .select_high_active_o(sh),
    .drive_n_o(dn), .store_n_o(st), .byte_lines_i(bus), .byte_lines_o(blo), .byte_lines_oe_n_o(oen));
  asbc_mem_model u_mem (.clk_i(clk_i), .slow_i(slow), .addr_i(addr), .sel_n_i(sn), .sel_i(sh),
    .drive_n_i(dn), .store_n_i(st), .data_i(blo), .data_o(mdat), .drive_o(mdrv));
  initial forever #4 clk_i = ~clk_i;
  task idle;
    integer i;
    begin
      i = 0;
      while (rdy !== 1'b1 && i < 200) begin @(negedge clk_i); i++; end
      `CHK("request ready", 1'b1, rdy)
    end
  endtask
  task req(input w, input [12:0] a, input [7:0] d);
    begin
      idle;
      rv = 1; rw = w; ra = a; rd = d;
      @(negedge clk_i);
      rv = 0;
    end
  endtask
  task rd_chk(input [12:0] a, input [7:0] e);
    integer i;
    begin
      req(0, a, 8'h00);
      i = 0;
      while (rsp !== 1'b1 && i < 40) begin @(negedge clk_i); i++; end
      `CHK("read response", 1'b1, rsp)
      `CHK("read data", e, rdat)
      @(negedge clk_i);
      `CHK("response pulse end", 1'b0, rsp)
      `CHK("read data held", e, rdat)
    end
  endtask
  task t_fast;
    begin
      req(1, 13'h0000, 8'ha5);
      req(1, 13'h1fff, 8'h5a);
      rd_chk(13'h0000, 8'ha5);
      rd_chk(13'h1fff, 8'h5a);
      $display("test fast grade done");
    end
  endtask
  task t_slow;
    begin
      idle; slow = 1;
      req(1, 13'h0155, 8'h3c);
      rd_chk(13'h0155, 8'h3c);
      req(1, 13'h0155, 8'hc3);
      rd_chk(13'h0155, 8'hc3);
      idle; slow = 0;
      $display("test slow grade done");
    end
  endtask
  task t_pause;
    begin
      req(1, 13'h0aaa, 8'h96);
      repeat (3) @(negedge clk_i);
      ce_i = 0;
      repeat (8) @(negedge clk_i);
      ce_i = 1;
      rd_chk(13'h0aaa, 8'h96);
      $display("test clock pause done");
    end
  endtask
  // Reset in the middle of a read, then normal traffic again
  task t_reset;
    begin
      req(0, 13'h0000, 8'h00);
      repeat (4) @(negedge clk_i);
      rst_i = 1;
      repeat (2) @(negedge clk_i);
      `CHK("pins in reset", 7'b101_1100, {sn, sh, dn, st, oen, rdy, rsp})
      rst_i = 0;
      rd_chk(13'h0000, 8'ha5);
      $display("test mid-run reset done");
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // About 300 cycles of traffic; ten times that means a hang
  initial begin
    #(8 * 3000);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 0;
    t_fast;
    t_slow;
    t_pause;
    t_reset;
    print_verdict;
  end
endmodule
